/* File: design/fgwt_pkg.sv */
package fgwt_pkg;

    // ************************************************************
    // Field positions of the write-trap control word
    // ************************************************************
    localparam int unsigned CTRL_W = 64;
    localparam int unsigned BIT_VECBASE = 38;
    localparam int unsigned BIT_UPPER_TB = 37;
    localparam int unsigned BIT_LOWER_TB = 36;
    localparam int unsigned BIT_USER_TID_RW = 35;
    localparam int unsigned BIT_USER_TID_RO = 34;
    localparam int unsigned BIT_KERN_TID = 33;
    localparam int unsigned BIT_XLATE_CTL = 32;
    localparam int unsigned BIT_USER_CTXNUM = 31;
    localparam int unsigned BIT_KERN_CTXNUM = 30;
    localparam int unsigned BIT_SYS_CTL = 29;
    localparam int unsigned BIT_PHYS_ADDR = 27;
    localparam int unsigned BIT_MEM_ATTR = 24;
    localparam int unsigned BIT_LO_REGION = 23;
    localparam int unsigned FIELD_LO = 23;
    localparam int unsigned FIELD_HI = 38;
    localparam int unsigned FIELD_W = 16;

    // Fields that exist regardless of optional features
    localparam logic [15:0] FIXED_MASK = 16'hFE52;
    localparam logic [15:0] CTXNUM_MASK = 16'h0180;
    localparam logic [15:0] LOREG_MASK = 16'h0001;
    localparam logic [15:0] FIELD_RESET = 16'h0000;

    // Syndrome exception class of a fine-grained write trap
    localparam logic [5:0] EC_FGT = 6'h18;

    // ************************************************************
    // Exception levels, execution states and target registers
    // ************************************************************
    typedef enum logic [1:0] {
        FGWT_USER_LEVEL,
        FGWT_KERNEL_LEVEL,
        FGWT_HYPERVISOR_LEVEL,
        FGWT_MONITOR_LEVEL
    } fgwt_level_t;

    typedef enum logic [4:0] {
        FGWT_REG_NONE,
        FGWT_REG_KERNEL_VECTOR_BASE,
        FGWT_REG_UPPER_TABLE_BASE,
        FGWT_REG_LOWER_TABLE_BASE,
        FGWT_REG_USER_THREAD_ID_RW,
        FGWT_REG_USER_THREAD_ID_RW_ALIAS32,
        FGWT_REG_USER_THREAD_ID_RO,
        FGWT_REG_KERNEL_THREAD_ID,
        FGWT_REG_TRANSLATION_CONTROL,
        FGWT_REG_TRANSLATION_CONTROL_EXT,
        FGWT_REG_USER_CONTEXT_NUMBER,
        FGWT_REG_KERNEL_CONTEXT_NUMBER,
        FGWT_REG_SYSTEM_CONTROL,
        FGWT_REG_SYSTEM_CONTROL_EXT,
        FGWT_REG_PHYS_ADDR_RESULT,
        FGWT_REG_MEM_ATTR_INDIRECTION,
        FGWT_REG_LO_REGION_START
    } fgwt_sysreg_t;

    // System register write request from the execution pipeline
    typedef struct packed {
        logic valid;
        fgwt_sysreg_t target;
        fgwt_level_t level;
        logic is_coproc;
        logic higher_prio_exc;
    } fgwt_req_t;

    // Processor context the trap decision depends on
    typedef struct packed {
        logic hyp_impl;
        logic hyp_enabled;
        logic monitor_impl;
        logic monitor_fine_trap_enable;
        logic host_kernel_e2h;
        logic host_kernel_tge;
        logic kernel_is_64;
        logic translation_ext_feature;
        logic sysctl_ext_feature;
        logic spec_context_feature_a;
        logic spec_context_feature_b;
        logic limited_order_region_feature;
    } fgwt_ctx_t;

    // Decision handed back to the exception logic
    typedef struct packed {
        logic valid;
        logic trap;
        logic pass_higher;
        logic [5:0] exc_class;
        fgwt_level_t target_level;
    } fgwt_resp_t;

endpackage

/* File: design/fgwt_field_reg.sv */
// One trap field: warm-reset clear, gated by its implementation flag
module fgwt_field_reg (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic present,
    input wire logic wr_en,
    input wire logic wr_bit,
    output logic q
);

    // ************************************************************
    // Storage
    // ************************************************************
    // Absent fields hold zero so they never trap and read as zero
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            q <= 1'b0;
        end
        else if (!present)
        begin
            q <= 1'b0;
        end
        else if (wr_en)
        begin
            q <= wr_bit;
        end
    end

endmodule

/* File: design/fgwt_trap_unit.sv */
// Overview of operation
// RQ1 - Trap needs hypervisor enabled and monitor permission
// RQ2 - Trapped write goes to hypervisor, class 0x18
// RQ3 - Higher priority exception wins over this trap
// RQ4 - Zero field never traps its registers
// RQ5 - All fields clear to zero on warm reset
// RQ6 - Bit 38 traps kernel vector base writes
// RQ7 - Bit 37 traps upper table base writes
// RQ8 - Bit 36 traps lower table base writes
// RQ9 - Bit 35 traps user thread-id and alias
// RQ10 - Thread-id trap needs pair not both, kernel 64
// RQ11 - Bit 34 traps user read-only thread-id writes
// RQ12 - Bit 33 traps kernel thread-id writes
// RQ13 - Bit 32 traps translation control and extension
// RQ14 - Bit 31 traps user context number writes
// RQ15 - Bit 30 traps kernel context number writes
// RQ16 - Context fields exist only with speculation feature
// RQ17 - Bit 29 traps system control and extension
// RQ18 - Bit 27 traps physical address result writes
// RQ19 - Bit 24 traps memory attribute indirection writes
// RQ20 - Bit 23 exists only with region feature
// RQ21 - Reserved bits 28, 26, 25 read zero
module fgwt_trap_unit (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic ctrl_wr_en,
    input wire logic [63:0] ctrl_wr_data,
    output logic [63:0] ctrl_rd_data,
    input wire fgwt_pkg::fgwt_req_t req,
    input wire fgwt_pkg::fgwt_ctx_t ctx,
    output fgwt_pkg::fgwt_resp_t resp
);

    // ************************************************************
    // Field storage
    // ************************************************************
    logic [15:0] field_q;
    logic [15:0] field_present;
    logic ctx_feat;

    // Which fields exist given the implemented features
    assign ctx_feat = ctx.spec_context_feature_a
                      | ctx.spec_context_feature_b;
    assign field_present = fgwt_pkg::FIXED_MASK
        | (ctx_feat ? fgwt_pkg::CTXNUM_MASK : 16'h0000) // RQ16
        | (ctx.limited_order_region_feature
           ? fgwt_pkg::LOREG_MASK : 16'h0000); // RQ20

    // One storage cell per field; reserved ones are never present
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++)
        begin : g_field
            fgwt_field_reg u_field (
                .core_clk(core_clk),
                .rstn(rstn), // RQ5
                .present(field_present[gi]), // RQ21
                .wr_en(ctrl_wr_en),
                .wr_bit(ctrl_wr_data[fgwt_pkg::FIELD_LO + gi]),
                .q(field_q[gi])
            );
        end
    endgenerate

    // ************************************************************
    // Register read path
    // ************************************************************
    logic [63:0] next_rd_data;

    // Fields in place, everything else reads zero
    assign next_rd_data = {25'h0000000, field_q, 23'h000000};

    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            ctrl_rd_data <= 64'h0000000000000000;
        end
        else
        begin
            ctrl_rd_data <= next_rd_data;
        end
    end

    // ************************************************************
    // Field selection by target register
    // ************************************************************
    logic kern_a64;
    logic usr_a64;
    logic usr_a32;
    logic pair_ok;
    logic field_hit;

    assign kern_a64 = (req.level == fgwt_pkg::FGWT_KERNEL_LEVEL)
                      && !req.is_coproc;
    assign usr_a64 = (req.level == fgwt_pkg::FGWT_USER_LEVEL)
                     && !req.is_coproc;
    assign usr_a32 = (req.level == fgwt_pkg::FGWT_USER_LEVEL)
                     && req.is_coproc;
    assign pair_ok = !(ctx.host_kernel_e2h && ctx.host_kernel_tge);

    function automatic logic fbit(input logic [15:0] f,
                                  input int unsigned pos);
        fbit = f[pos - fgwt_pkg::FIELD_LO];
    endfunction

    // Field and level qualification per target register
    always_comb
    begin
        field_hit = 1'b0;
        case (req.target)
            fgwt_pkg::FGWT_REG_KERNEL_VECTOR_BASE:
                field_hit = kern_a64 // RQ6
                    && fbit(field_q, fgwt_pkg::BIT_VECBASE);
            fgwt_pkg::FGWT_REG_UPPER_TABLE_BASE:
                field_hit = kern_a64 // RQ7
                    && fbit(field_q, fgwt_pkg::BIT_UPPER_TB);
            fgwt_pkg::FGWT_REG_LOWER_TABLE_BASE:
                field_hit = kern_a64 // RQ8
                    && fbit(field_q, fgwt_pkg::BIT_LOWER_TB);
            fgwt_pkg::FGWT_REG_USER_THREAD_ID_RW:
                field_hit = (kern_a64 || usr_a64) // RQ9
                    && pair_ok && ctx.kernel_is_64 // RQ10
                    && fbit(field_q, fgwt_pkg::BIT_USER_TID_RW);
            fgwt_pkg::FGWT_REG_USER_THREAD_ID_RW_ALIAS32:
                field_hit = usr_a32 // RQ9
                    && pair_ok && ctx.kernel_is_64 // RQ10
                    && fbit(field_q, fgwt_pkg::BIT_USER_TID_RW);
            fgwt_pkg::FGWT_REG_USER_THREAD_ID_RO:
                field_hit = kern_a64 // RQ11
                    && fbit(field_q, fgwt_pkg::BIT_USER_TID_RO);
            fgwt_pkg::FGWT_REG_KERNEL_THREAD_ID:
                field_hit = kern_a64 // RQ12
                    && fbit(field_q, fgwt_pkg::BIT_KERN_TID);
            fgwt_pkg::FGWT_REG_TRANSLATION_CONTROL:
                field_hit = kern_a64 // RQ13
                    && fbit(field_q, fgwt_pkg::BIT_XLATE_CTL);
            fgwt_pkg::FGWT_REG_TRANSLATION_CONTROL_EXT:
                field_hit = kern_a64 && ctx.translation_ext_feature
                    && fbit(field_q, fgwt_pkg::BIT_XLATE_CTL); // RQ13
            fgwt_pkg::FGWT_REG_USER_CONTEXT_NUMBER:
                field_hit = (kern_a64 || usr_a64) && pair_ok // RQ14
                    && fbit(field_q, fgwt_pkg::BIT_USER_CTXNUM);
            fgwt_pkg::FGWT_REG_KERNEL_CONTEXT_NUMBER:
                field_hit = kern_a64 // RQ15
                    && fbit(field_q, fgwt_pkg::BIT_KERN_CTXNUM);
            fgwt_pkg::FGWT_REG_SYSTEM_CONTROL:
                field_hit = kern_a64 // RQ17
                    && fbit(field_q, fgwt_pkg::BIT_SYS_CTL);
            fgwt_pkg::FGWT_REG_SYSTEM_CONTROL_EXT:
                field_hit = kern_a64 && ctx.sysctl_ext_feature
                    && fbit(field_q, fgwt_pkg::BIT_SYS_CTL); // RQ17
            fgwt_pkg::FGWT_REG_PHYS_ADDR_RESULT:
                field_hit = kern_a64 // RQ18
                    && fbit(field_q, fgwt_pkg::BIT_PHYS_ADDR);
            fgwt_pkg::FGWT_REG_MEM_ATTR_INDIRECTION:
                field_hit = kern_a64 // RQ19
                    && fbit(field_q, fgwt_pkg::BIT_MEM_ATTR);
            fgwt_pkg::FGWT_REG_LO_REGION_START:
                field_hit = kern_a64 // RQ20
                    && fbit(field_q, fgwt_pkg::BIT_LO_REGION);
            default:
                field_hit = 1'b0; // RQ4
        endcase
    end

    // ************************************************************
    // Trap decision
    // ************************************************************
    logic gate_ok;
    logic next_trap;
    fgwt_pkg::fgwt_resp_t next_resp;

    // Hypervisor live and monitor permits fine-grained traps
    assign gate_ok = ctx.hyp_impl && ctx.hyp_enabled // RQ1
        && (!ctx.monitor_impl || ctx.monitor_fine_trap_enable);
    assign next_trap = req.valid && gate_ok && field_hit
                       && !req.higher_prio_exc; // RQ3

    always_comb
    begin
        next_resp = '0;
        next_resp.valid = req.valid;
        next_resp.trap = next_trap;
        next_resp.pass_higher = req.valid && req.higher_prio_exc; // RQ3
        next_resp.exc_class = next_trap ? fgwt_pkg::EC_FGT : 6'h00;
        next_resp.target_level = next_trap
            ? fgwt_pkg::FGWT_HYPERVISOR_LEVEL // RQ2
            : fgwt_pkg::FGWT_USER_LEVEL;
    end

    // Registered decision, one cycle after the request
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            resp <= '0;
        end
        else
        begin
            resp <= next_resp;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    // Write that passes every gate except its own trap field
    logic chk_gate;
    logic live_kern;
    logic tid_ok;

    assign chk_gate = ctx.hyp_impl && ctx.hyp_enabled
        && (!ctx.monitor_impl || ctx.monitor_fine_trap_enable);
    assign live_kern = req.valid && !req.higher_prio_exc && chk_gate
        && (req.level == fgwt_pkg::FGWT_KERNEL_LEVEL) && !req.is_coproc;
    assign tid_ok = ctx.kernel_is_64
        && !(ctx.host_kernel_e2h && ctx.host_kernel_tge);

    // Gate conditions, class, priority and reset
    AST_GATE: assert property (@(posedge core_clk) // RQ1
        disable iff (!rstn)
        (!ctx.hyp_impl || !ctx.hyp_enabled) |=> !resp.trap)
        else $error("trap without enabled hypervisor");
    AST_MONITOR: assert property (@(posedge core_clk) // RQ1
        disable iff (!rstn)
        (ctx.monitor_impl && !ctx.monitor_fine_trap_enable)
        |=> !resp.trap)
        else $error("trap while monitor forbids it");
    AST_CLASS: assert property (@(posedge core_clk) // RQ2
        disable iff (!rstn)
        resp.trap |-> (resp.exc_class == fgwt_pkg::EC_FGT
        && resp.target_level == fgwt_pkg::FGWT_HYPERVISOR_LEVEL))
        else $error("bad trap class or target");
    AST_PRIO: assert property (@(posedge core_clk) // RQ3
        disable iff (!rstn)
        (req.valid && req.higher_prio_exc)
        |=> (!resp.trap && resp.pass_higher))
        else $error("trap beat higher priority exception");
    AST_ZERO: assert property (@(posedge core_clk) // RQ4
        disable iff (!rstn)
        (field_q == 16'h0000) |=> !resp.trap)
        else $error("trap with all fields zero");
    AST_RESET: assert property (@(posedge core_clk) // RQ5
        !rstn |=> (ctrl_rd_data == 64'h0 && field_q == 16'h0))
        else $error("fields not cleared by reset");
    AST_PAIR: assert property (@(posedge core_clk) // RQ14
        disable iff (!rstn)
        (req.target == fgwt_pkg::FGWT_REG_USER_CONTEXT_NUMBER
         && ctx.host_kernel_e2h && ctx.host_kernel_tge)
        |=> !resp.trap)
        else $error("context trap with pair both set");
    AST_TID32: assert property (@(posedge core_clk) // RQ10
        disable iff (!rstn)
        (req.target == fgwt_pkg::FGWT_REG_USER_THREAD_ID_RW
         && !ctx.kernel_is_64) |=> !resp.trap)
        else $error("thread-id trap with 32-bit kernel");
    AST_RSVD: assert property (@(posedge core_clk) // RQ21
        disable iff (!rstn)
        ctrl_wr_en |=> ##1 (ctrl_rd_data[28] == 1'b0
        && ctrl_rd_data[26:25] == 2'b00))
        else $error("reserved bit reads nonzero");
    // Field clears one edge after the drop, readback one edge later
    AST_CTXFEAT: assert property (@(posedge core_clk) // RQ16
        disable iff (!rstn)
        (!ctx.spec_context_feature_a && !ctx.spec_context_feature_b)
        [*3] |-> ctrl_rd_data[31:30] == 2'b00)
        else $error("context field present without feature");

    // A set field traps its own qualifying write
    AST_VECBASE: assert property (@(posedge core_clk) // RQ6
        disable iff (!rstn)
        (live_kern && fbit(field_q, fgwt_pkg::BIT_VECBASE)
         && req.target == fgwt_pkg::FGWT_REG_KERNEL_VECTOR_BASE)
        |=> resp.trap)
        else $error("vector base write not trapped");
    AST_UPPER_TB: assert property (@(posedge core_clk) // RQ7
        disable iff (!rstn)
        (live_kern && fbit(field_q, fgwt_pkg::BIT_UPPER_TB)
         && req.target == fgwt_pkg::FGWT_REG_UPPER_TABLE_BASE)
        |=> resp.trap)
        else $error("upper table base write not trapped");
    AST_LOWER_TB: assert property (@(posedge core_clk) // RQ8
        disable iff (!rstn)
        (live_kern && fbit(field_q, fgwt_pkg::BIT_LOWER_TB)
         && req.target == fgwt_pkg::FGWT_REG_LOWER_TABLE_BASE)
        |=> resp.trap)
        else $error("lower table base write not trapped");
    AST_TIDRW: assert property (@(posedge core_clk) // RQ9
        disable iff (!rstn)
        (live_kern && tid_ok && fbit(field_q, fgwt_pkg::BIT_USER_TID_RW)
         && req.target == fgwt_pkg::FGWT_REG_USER_THREAD_ID_RW)
        |=> resp.trap)
        else $error("user thread-id write not trapped");
    AST_TIDRO: assert property (@(posedge core_clk) // RQ11
        disable iff (!rstn)
        (live_kern && fbit(field_q, fgwt_pkg::BIT_USER_TID_RO)
         && req.target == fgwt_pkg::FGWT_REG_USER_THREAD_ID_RO)
        |=> resp.trap)
        else $error("read-only thread-id write not trapped");
    AST_KTID: assert property (@(posedge core_clk) // RQ12
        disable iff (!rstn)
        (live_kern && fbit(field_q, fgwt_pkg::BIT_KERN_TID)
         && req.target == fgwt_pkg::FGWT_REG_KERNEL_THREAD_ID)
        |=> resp.trap)
        else $error("kernel thread-id write not trapped");
    AST_XLATE: assert property (@(posedge core_clk) // RQ13
        disable iff (!rstn)
        (live_kern && fbit(field_q, fgwt_pkg::BIT_XLATE_CTL)
         && req.target == fgwt_pkg::FGWT_REG_TRANSLATION_CONTROL)
        |=> resp.trap)
        else $error("translation control write not trapped");
    AST_UCTX: assert property (@(posedge core_clk) // RQ14
        disable iff (!rstn)
        (live_kern && tid_ok && fbit(field_q, fgwt_pkg::BIT_USER_CTXNUM)
         && req.target == fgwt_pkg::FGWT_REG_USER_CONTEXT_NUMBER)
        |=> resp.trap)
        else $error("user context write not trapped");
    AST_KCTX: assert property (@(posedge core_clk) // RQ15
        disable iff (!rstn)
        (live_kern && fbit(field_q, fgwt_pkg::BIT_KERN_CTXNUM)
         && req.target == fgwt_pkg::FGWT_REG_KERNEL_CONTEXT_NUMBER)
        |=> resp.trap)
        else $error("kernel context write not trapped");
    AST_SYSCTL: assert property (@(posedge core_clk) // RQ17
        disable iff (!rstn)
        (live_kern && fbit(field_q, fgwt_pkg::BIT_SYS_CTL)
         && req.target == fgwt_pkg::FGWT_REG_SYSTEM_CONTROL)
        |=> resp.trap)
        else $error("system control write not trapped");
    AST_PHYS: assert property (@(posedge core_clk) // RQ18
        disable iff (!rstn)
        (live_kern && fbit(field_q, fgwt_pkg::BIT_PHYS_ADDR)
         && req.target == fgwt_pkg::FGWT_REG_PHYS_ADDR_RESULT)
        |=> resp.trap)
        else $error("address result write not trapped");
    AST_MEMATTR: assert property (@(posedge core_clk) // RQ19
        disable iff (!rstn)
        (live_kern && fbit(field_q, fgwt_pkg::BIT_MEM_ATTR)
         && req.target == fgwt_pkg::FGWT_REG_MEM_ATTR_INDIRECTION)
        |=> resp.trap)
        else $error("attribute write not trapped");
    AST_LOREG: assert property (@(posedge core_clk) // RQ20
        disable iff (!rstn)
        (live_kern && fbit(field_q, fgwt_pkg::BIT_LO_REGION)
         && req.target == fgwt_pkg::FGWT_REG_LO_REGION_START)
        |=> resp.trap)
        else $error("region start write not trapped");

endmodule

/* File: verification/fgwt_cpu_model.sv */
// ************************************************************
// Execution pipeline model issuing system register writes
// ************************************************************
module fgwt_cpu_model (
    input wire logic core_clk,
    output fgwt_pkg::fgwt_req_t req
);
    timeunit 1ns;
    timeprecision 1ns;

    // Idle request bus until the first write is issued
    initial
    begin
        req = '0;
    end

    // Present one write; it stays valid until the next call or idle
    task automatic issue(input logic [4:0] tgt, input logic [1:0] lvl,
                         input logic cop, input logic hp);
        @(negedge core_clk);
        req.valid = 1'b1;
        req.target = fgwt_pkg::fgwt_sysreg_t'(tgt);
        req.level = fgwt_pkg::fgwt_level_t'(lvl);
        req.is_coproc = cop;
        req.higher_prio_exc = hp;
    endtask

    // Release the bus; qualifiers flip so stale values never match
    task automatic idle();
        @(negedge core_clk);
        req.valid = 1'b0;
        req.target = fgwt_pkg::fgwt_sysreg_t'(~req.target);
        req.level = fgwt_pkg::fgwt_level_t'(~req.level);
        req.is_coproc = ~req.is_coproc;
        req.higher_prio_exc = ~req.higher_prio_exc;
    endtask
endmodule

/* File: verification/fgwt_trap_unit_tb.sv */
module fgwt_trap_unit_tb;
    timeunit 1ns;
    timeprecision 1ns;

    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic ctrl_wr_en = 1'b0;
    logic [63:0] ctrl_wr_data = 64'h0;
    logic [63:0] ctrl_rd_data;
    fgwt_pkg::fgwt_req_t req;
    fgwt_pkg::fgwt_ctx_t ctx = 12'hF3F;
    fgwt_pkg::fgwt_resp_t resp;
    fgwt_pkg::fgwt_resp_t exp_resp = '0;
    logic [15:0] exp_f = 16'h0;
    logic [63:0] exp_rd = 64'h0;
    int err_count = 0;
    int n_compared = 0;
    int cyc = 0;
    bit chk = 1'b0;
    // Field bit of each target, in enum order
    int pos_tab [17] = '{0, 38, 37, 36, 35, 35, 34, 33, 32, 32,
                         31, 30, 29, 29, 27, 24, 23};

    always #50 core_clk = ~core_clk;

    fgwt_trap_unit i_fgwt_trap_unit (
        .core_clk(core_clk),
        .rstn(rstn),
        .ctrl_wr_en(ctrl_wr_en),
        .ctrl_wr_data(ctrl_wr_data),
        .ctrl_rd_data(ctrl_rd_data),
        .req(req),
        .ctx(ctx),
        .resp(resp)
    );

    fgwt_cpu_model i_fgwt_cpu_model (
        .core_clk(core_clk),
        .req(req)
    );

    // ************************************************************
    // Expectation functions
    // ************************************************************
    function automatic logic [15:0] present(fgwt_pkg::fgwt_ctx_t c);
        return fgwt_pkg::FIXED_MASK
            | ({16{c.spec_context_feature_a | c.spec_context_feature_b}}
               & fgwt_pkg::CTXNUM_MASK)
            | ({16{c.limited_order_region_feature}} & fgwt_pkg::LOREG_MASK);
    endfunction

    function automatic fgwt_pkg::fgwt_resp_t predict(logic [15:0] f,
        fgwt_pkg::fgwt_req_t r, fgwt_pkg::fgwt_ctx_t c);
        int t;
        logic ok;
        logic gate;
        logic fld;
        logic pair;
        fgwt_pkg::fgwt_resp_t e;
        t = int'(r.target);
        pair = c.host_kernel_e2h & c.host_kernel_tge;
        gate = c.hyp_impl & c.hyp_enabled
            & (!c.monitor_impl | c.monitor_fine_trap_enable);
        ok = r.level == fgwt_pkg::FGWT_KERNEL_LEVEL && !r.is_coproc;
        if (t == 4 || t == 10)
            ok = !r.is_coproc && (r.level == fgwt_pkg::FGWT_USER_LEVEL
                || r.level == fgwt_pkg::FGWT_KERNEL_LEVEL);
        if (t == 5)
            ok = r.is_coproc && r.level == fgwt_pkg::FGWT_USER_LEVEL;
        if (t == 4 || t == 5)
            ok = ok & c.kernel_is_64 & !pair;
        if (t == 10)
            ok = ok & !pair;
        if (t == 9)
            ok = ok & c.translation_ext_feature;
        if (t == 13)
            ok = ok & c.sysctl_ext_feature;
        fld = (t >= 1 && t <= 16) ? f[pos_tab[t] - 23] : 1'b0;
        e.valid = r.valid;
        e.trap = r.valid & !r.higher_prio_exc & gate & ok & fld;
        e.pass_higher = r.valid & r.higher_prio_exc;
        e.exc_class = e.trap ? fgwt_pkg::EC_FGT : 6'h00;
        e.target_level = e.trap ? fgwt_pkg::FGWT_HYPERVISOR_LEVEL
                                : fgwt_pkg::FGWT_USER_LEVEL;
        return e;
    endfunction

    // Reference copy of the fields, readback and decision
    always @(posedge core_clk)
    begin
        exp_resp <= rstn ? predict(exp_f, req, ctx) : '0;
        exp_rd <= rstn ? {25'h0, exp_f, 23'h0} : 64'h0;
        if (!rstn)
            exp_f <= 16'h0;
        else if (ctrl_wr_en)
            exp_f <= ctrl_wr_data[38:23] & present(ctx);
        else
            exp_f <= exp_f & present(ctx);
    end

    // ************************************************************
    // Compare and report tasks
    // ************************************************************
    task automatic cmp_word(input logic [63:0] g, input logic [63:0] e);
        n_compared++;
        if (g !== e)
        begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic cmp_resp(input fgwt_pkg::fgwt_resp_t g,
                            input fgwt_pkg::fgwt_resp_t e);
        n_compared++;
        if (g !== e)
        begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic report_and_stop();
        $display("compared=%0d errors=%0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Settled outputs checked every cycle; hang cut short
    always @(negedge core_clk)
    begin
        cyc++;
        if (chk)
        begin
            cmp_word(ctrl_rd_data, exp_rd);
            cmp_resp(resp,
                     exp_resp);
        end
        if (cyc > 20000)
        begin
            err_count++;
            report_and_stop();
        end
    end

    // ************************************************************
    // Stimulus
    // ************************************************************
    task automatic wr(input logic [63:0] d);
        @(negedge core_clk);
        ctrl_wr_en = 1'b1;
        ctrl_wr_data = d;
        @(negedge core_clk);
        ctrl_wr_en = 1'b0;
        ctrl_wr_data = ~d;
    endtask

    task automatic sweep();
        for (int t = 0; t < 17; t++)
            for (int l = 0; l < 4; l++)
                for (int c = 0; c < 2; c++)
                    i_fgwt_cpu_model.issue(5'(t), 2'(l), 1'(c), 1'b0);
    endtask

    initial
    begin
        void'($urandom(32'hCDE95207));
        repeat (2) @(negedge core_clk);
        chk = 1'b1;
        repeat (8) @(negedge core_clk);
        rstn = 1'b1;
        // All fields set, every target, level and width
        wr(64'hFFFF_FFFF_FFFF_FFFF);
        sweep();
        // Gate and host-kernel pair combinations
        for (int c = 0; c < 64; c++)
        begin
            @(negedge core_clk);
            ctx = fgwt_pkg::fgwt_ctx_t'({6'(c), 6'h3F});
            i_fgwt_cpu_model.issue(5'd4, 2'd1, 1'b0, 1'b0);
            i_fgwt_cpu_model.issue(5'd10, 2'd0, 1'b0, 1'b0);
            i_fgwt_cpu_model.issue(5'd1, 2'd1, 1'b0, c[0]);
        end
        // Optional features except translation extension dropped, then restored
        @(negedge core_clk);
        ctx = 12'hF30;
        sweep();
        @(negedge core_clk);
        ctx = 12'hF3F;
        sweep();
        // Cleared fields never trap
        wr(64'h0);
        sweep();
        // Random traffic with random writes and contexts
        repeat (600)
        begin
            if ($urandom % 8 == 0)
                wr({$urandom, $urandom});
            if ($urandom % 16 == 0)
                ctx = fgwt_pkg::fgwt_ctx_t'(12'($urandom) | 12'hC00);
            i_fgwt_cpu_model.issue(5'($urandom % 17), 2'($urandom),
                                   1'($urandom), 1'($urandom % 8 == 0));
        end
        // Warm reset in mid-run clears every field
        @(negedge core_clk);
        rstn = 1'b0;
        repeat (2) @(negedge core_clk);
        rstn = 1'b1;
        sweep();
        i_fgwt_cpu_model.idle();
        repeat (3) @(negedge core_clk);
        report_and_stop();
    end
endmodule
